// [ppx_defs.vh]
// Opcodes, field positions and constants for the peripheral-processor execution block
`ifndef PPX_DEFS_VH
`define PPX_DEFS_VH
`define PPX_OP_JUMP_ALWAYS 10'h003
`define PPX_OP_JUMP_ZERO 10'h004
`define PPX_OP_JUMP_NONZERO 10'h005
`define PPX_OP_JUMP_PLUS 10'h006
`define PPX_OP_REPLACE_ADD 10'h02d
`define PPX_OP_INC 10'h02e
`define PPX_OP_DEC 10'h02f
`define PPX_OP_DEC_IND_LONG 10'h227
`define PPX_OP_REPLACE_ADD_LONG 10'h22d
`define PPX_OP_INC_LONG 10'h22e
`define PPX_OP_DEC_LONG 10'h22f
`define PPX_LONG_BIT 9
`define PPX_ACC_PLUS_ONE 18'h00001
`define PPX_ACC_MINUS_ONE 18'h3fffe
`define PPX_ACC_SIGN 17
`define PPX_SHORT_MASK 16'h0fff
`define PPX_DISP_SIGN 5
`define PPX_DISP_ALL_ONES 6'h3f
`define PPX_ZERO_D 6'h00
`endif

// [ppx_ones_add.v]
// Ones complement adder with end-around carry
`timescale 1ns/1ps
module ppx_ones_add #(
   parameter W = 18
) (
   input wire [W-1:0] a,
   input wire [W-1:0] b,
   output wire [W-1:0] sum
);
   wire [W:0] raw;
   assign raw = {1'b0, a} + {1'b0, b};
   // End-around carry folds the overflow back into bit zero
   assign sum = raw[W-1:0] + {{(W-1){1'b0}}, raw[W]};
endmodule // ppx_ones_add

// [ppx_exec.v]
// Execution logic for replace/increment/decrement and short relative branches
// Function
// RULE_01 - Long indirect decrement: read 16 bits, add minus one, write back.
// RULE_02 - Long indirect decrement addresses the word held at location d.
// RULE_03 - Accumulator sums are 18-bit ones complement, full sum stays in accumulator.
// RULE_04 - Short operands are 12-bit positive, zero-extended to 18 bits.
// RULE_05 - Long operands are 16-bit positive, zero-extended to 18 bits.
// RULE_06 - Short write-back is low 12 accumulator bits with four zeros above.
// RULE_07 - Long write-back is low 16 accumulator bits to operand location.
// RULE_08 - Short indexed replace-add adds operand to accumulator and stores it.
// RULE_09 - Long indexed replace-add adds operand to accumulator and stores it.
// RULE_10 - Short indexed increment loads plus one, adds operand, stores back.
// RULE_11 - Long indexed increment loads plus one, adds operand, stores back.
// RULE_12 - Short indexed decrement loads minus one, adds operand, stores back.
// RULE_13 - Long indexed decrement loads minus one, adds operand, stores back.
// RULE_14 - Indexed address is m plus word at d, 12-bit ones complement.
// RULE_15 - Indexed address is m alone when d is zero.
// RULE_16 - Branch displacement: 0-31 forward d, 32-63 backward 63 minus d.
// RULE_17 - Unconditional short jump always moves by displacement.
// RULE_18 - Zero jump branches only when accumulator is all zero.
// RULE_19 - Non-zero jump branches only when some accumulator bit set.
// RULE_20 - Plus jump branches only when accumulator sign bit is clear.
// RULE_21 - Untaken conditional jump goes to next instruction, accumulator unchanged.
`timescale 1ns/1ps
`include "ppx_defs.vh"
module ppx_exec #(
   parameter AW = 12,
   parameter DW = 16,
   parameter ACCW = 18
) (
   input wire REF_CLK,
   input wire RST,
   // Instruction issue: opcode, d field, second word m, current program address
   input wire START,
   input wire [9:0] OPCODE,
   input wire [5:0] D_FIELD,
   input wire [DW-1:0] M_FIELD,
   input wire [AW-1:0] PROG_ADDR,
   output wire BUSY,
   output reg DONE,
   output reg ILLEGAL,
   output reg [AW-1:0] NEXT_PROG_ADDR,
   output reg [ACCW-1:0] ACC,
   // Processor memory, single word per request, data one cycle after read
   output reg MEM_RD,
   output reg MEM_WR,
   output reg [AW-1:0] MEM_ADDR,
   output reg [DW-1:0] MEM_WDATA,
   input wire [DW-1:0] MEM_RDATA
);
   localparam S_IDLE = 6'b000001;
   localparam S_PTR = 6'b000010;
   localparam S_PTRW = 6'b000100;
   localparam S_OPR = 6'b001000;
   localparam S_OPW = 6'b010000;
   localparam S_WB = 6'b100000;

   reg [5:0] state;
   reg [9:0] op;
   reg [5:0] dfld;
   reg [AW-1:0] mfld;
   reg [AW-1:0] paddr;
   reg [AW-1:0] oaddr;
   reg [ACCW-1:0] next_acc;

   ////////////////////////////////////////////////////////////////////////
   function is_long;
      input [9:0] code;
      begin
         is_long = code[`PPX_LONG_BIT];
      end
   endfunction

   function is_memop;
      input [9:0] code;
      begin
         case (code)
            `PPX_OP_REPLACE_ADD, `PPX_OP_INC, `PPX_OP_DEC, `PPX_OP_DEC_IND_LONG,
            `PPX_OP_REPLACE_ADD_LONG, `PPX_OP_INC_LONG, `PPX_OP_DEC_LONG: is_memop = 1'b1;
            default: is_memop = 1'b0;
         endcase
      end
   endfunction

   function is_jump;
      input [9:0] code;
      begin
         is_jump = (code == `PPX_OP_JUMP_ALWAYS) || (code == `PPX_OP_JUMP_ZERO) ||
            (code == `PPX_OP_JUMP_NONZERO) || (code == `PPX_OP_JUMP_PLUS);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Index sum m + (d)
   wire [AW-1:0] idx_sum;
   ppx_ones_add #(
      .W(AW)
   ) u_index_add (
      .a(mfld),
      .b(MEM_RDATA[AW-1:0]),
      .sum(idx_sum)
   );

   // Operand extension and the accumulator start value
   wire [ACCW-1:0] operand;
   wire [ACCW-1:0] acc_base;
   wire [ACCW-1:0] acc_sum;
   // RULE_04 Short zero extension
   // RULE_05 Long zero extension
   assign operand = is_long(op) ? {{(ACCW-DW){1'b0}}, MEM_RDATA} :
      {{(ACCW-AW){1'b0}}, MEM_RDATA[AW-1:0]};
   // RULE_10 Plus one preload
   // RULE_11 Plus one preload
   // RULE_12 Minus one preload
   // RULE_13 Minus one preload
   // RULE_01 Minus one preload
   assign acc_base = (op == `PPX_OP_INC || op == `PPX_OP_INC_LONG) ? `PPX_ACC_PLUS_ONE :
      (op == `PPX_OP_DEC || op == `PPX_OP_DEC_LONG || op == `PPX_OP_DEC_IND_LONG) ?
      `PPX_ACC_MINUS_ONE : ACC;
   // RULE_03 Ones complement sum
   ppx_ones_add #(
      .W(ACCW)
   ) u_acc_add (
      .a(acc_base),
      .b(operand),
      .sum(acc_sum)
   );

   ////////////////////////////////////////////////////////////////////////
   // Branch target
   wire [AW-1:0] seq_addr;
   wire [AW-1:0] jump_addr;
   wire take_jump;
   assign seq_addr = PROG_ADDR + {{(AW-1){1'b0}}, 1'b1};
   // RULE_16 Ones complement displacement; backward by 63 minus d
   assign jump_addr = D_FIELD[`PPX_DISP_SIGN] ?
      PROG_ADDR - {{(AW-6){1'b0}}, (`PPX_DISP_ALL_ONES - D_FIELD)} :
      PROG_ADDR + {{(AW-6){1'b0}}, D_FIELD};
   // RULE_17 Always taken
   // RULE_18 All bits clear
   // RULE_19 Any bit set
   // RULE_20 Sign bit clear
   assign take_jump = (OPCODE == `PPX_OP_JUMP_ALWAYS) ||
      (OPCODE == `PPX_OP_JUMP_ZERO && ACC == {ACCW{1'b0}}) ||
      (OPCODE == `PPX_OP_JUMP_NONZERO && ACC != {ACCW{1'b0}}) ||
      (OPCODE == `PPX_OP_JUMP_PLUS && !ACC[`PPX_ACC_SIGN]);

   assign BUSY = (state != S_IDLE);

   ////////////////////////////////////////////////////////////////////////
   always @(posedge REF_CLK) begin
      if (RST) begin
         state <= S_IDLE;
         op <= 10'h000;
         dfld <= 6'h00;
         mfld <= {AW{1'b0}};
         paddr <= {AW{1'b0}};
         oaddr <= {AW{1'b0}};
         ACC <= {ACCW{1'b0}};
         DONE <= 1'b0;
         ILLEGAL <= 1'b0;
         NEXT_PROG_ADDR <= {AW{1'b0}};
         MEM_RD <= 1'b0;
         MEM_WR <= 1'b0;
         MEM_ADDR <= {AW{1'b0}};
         MEM_WDATA <= {DW{1'b0}};
      end else begin
         DONE <= 1'b0;
         ILLEGAL <= 1'b0;
         MEM_RD <= 1'b0;
         MEM_WR <= 1'b0;
         case (state)
            S_IDLE: begin
               if (START) begin
                  op <= OPCODE;
                  dfld <= D_FIELD;
                  mfld <= M_FIELD[AW-1:0];
                  paddr <= PROG_ADDR;
                  if (is_jump(OPCODE)) begin
                     DONE <= 1'b1;
                     // RULE_21 Untaken falls through
                     NEXT_PROG_ADDR <= take_jump ? jump_addr : seq_addr;
                  end else if (is_memop(OPCODE)) begin
                     if (OPCODE == `PPX_OP_DEC_IND_LONG || D_FIELD != `PPX_ZERO_D) begin
                        // Fetch the word at d: pointer or index
                        MEM_RD <= 1'b1;
                        MEM_ADDR <= {{(AW-6){1'b0}}, D_FIELD};
                        state <= S_PTR;
                     end else begin
                        // RULE_15 d zero uses m alone
                        MEM_RD <= 1'b1;
                        MEM_ADDR <= M_FIELD[AW-1:0];
                        oaddr <= M_FIELD[AW-1:0];
                        state <= S_OPR;
                     end
                  end else begin
                     // Opcodes outside this group are flagged, not executed
                     ILLEGAL <= 1'b1;
                     DONE <= 1'b1;
                     NEXT_PROG_ADDR <= seq_addr;
                  end
               end
            end
            S_PTR: begin
               state <= S_PTRW;
            end
            S_PTRW: begin
               MEM_RD <= 1'b1;
               if (op == `PPX_OP_DEC_IND_LONG) begin
                  // RULE_02 Indirect address from (d)
                  MEM_ADDR <= MEM_RDATA[AW-1:0];
                  oaddr <= MEM_RDATA[AW-1:0];
               end else begin
                  // RULE_14 Indexed ones complement address
                  MEM_ADDR <= idx_sum;
                  oaddr <= idx_sum;
               end
               state <= S_OPR;
            end
            S_OPR: begin
               state <= S_OPW;
            end
            S_OPW: begin
               // RULE_08 Replace-add short
               // RULE_09 Replace-add long
               ACC <= acc_sum;
               MEM_WR <= 1'b1;
               MEM_ADDR <= oaddr;
               // RULE_06 Short write-back masked
               // RULE_07 Long write-back low 16 bits
               MEM_WDATA <= is_long(op) ? acc_sum[DW-1:0] : (acc_sum[DW-1:0] & `PPX_SHORT_MASK);
               state <= S_WB;
            end
            S_WB: begin
               DONE <= 1'b1;
               // Indexed forms carry a second word
               NEXT_PROG_ADDR <= paddr + ((op == `PPX_OP_DEC_IND_LONG) ?
                  {{(AW-1){1'b0}}, 1'b1} : {{(AW-2){1'b0}}, 2'b10});
               state <= S_IDLE;
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end
endmodule // ppx_exec

// [ppx_exec_assertions.sv]
// Port checker for the execution block
`timescale 1ns/1ps
module ppx_exec_assertions #(
   parameter AW = 12,
   parameter DW = 16,
   parameter ACCW = 18
) (
   input wire REF_CLK,
   input wire RST,
   input wire START,
   input wire [9:0] OPCODE,
   input wire [5:0] D_FIELD,
   input wire [DW-1:0] M_FIELD,
   input wire [AW-1:0] PROG_ADDR,
   input wire BUSY,
   input wire DONE,
   input wire [AW-1:0] NEXT_PROG_ADDR,
   input wire [ACCW-1:0] ACC,
   input wire MEM_RD,
   input wire MEM_WR,
   input wire [AW-1:0] MEM_ADDR,
   input wire [DW-1:0] MEM_WDATA
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   wire go = START && !BUSY;
   wire jmp = OPCODE >= 10'h003 && OPCODE <= 10'h006;
   wire mop = (OPCODE[8:2] == 7'h0b && OPCODE[1:0] != 2'b00) || OPCODE == 10'h227;
   wire neg = ACC[ACCW-1];
   wire [AW-1:0] m_lo = M_FIELD[AW-1:0];
   wire [AW-1:0] p1 = PROG_ADDR + 1'b1;
   wire [AW-1:0] tgt = D_FIELD[5] ? PROG_ADDR - (6'h3f - D_FIELD) : PROG_ADDR + D_FIELD;
   reg [AW-1:0] rd_a;
   reg lng;
   // Operand address and width, kept for the write-back
   always @(posedge REF_CLK) begin
      if (MEM_RD) rd_a <= MEM_ADDR;
      if (go) lng <= OPCODE[9];
   end
   a_jump_acc: assert property (go && jmp |=> DONE && ACC == $past(ACC))
      else $error("jump late or acc changed");
   a_jump_always: assert property (go && OPCODE == 10'h003 |=> NEXT_PROG_ADDR == $past(tgt))
      else $error("jump target wrong");
   a_jump_zero: assert property (go && OPCODE == 10'h004 |=>
      NEXT_PROG_ADDR == (($past(ACC) == 0) ? $past(tgt) : $past(p1))) else $error("zero jump wrong");
   a_jump_nonzero: assert property (go && OPCODE == 10'h005 |=>
      NEXT_PROG_ADDR == (($past(ACC) != 0) ? $past(tgt) : $past(p1))) else $error("nonzero jump wrong");
   a_jump_plus: assert property (go && OPCODE == 10'h006 |=>
      NEXT_PROG_ADDR == ($past(neg) ? $past(p1) : $past(tgt))) else $error("plus jump wrong");
   a_index_ptr: assert property (go && mop && D_FIELD != 6'h00 |=> MEM_RD && MEM_ADDR == $past(D_FIELD))
      else $error("pointer fetch wrong");
   a_direct_m: assert property (go && mop && OPCODE != 10'h227 && D_FIELD == 6'h00 |=>
      MEM_RD && MEM_ADDR == $past(m_lo)) else $error("direct address wrong");
   a_wr_same: assert property (MEM_WR |-> MEM_ADDR == rd_a)
      else $error("write address differs from read");
   a_wr_data: assert property (MEM_WR |-> MEM_WDATA == (lng ? ACC[15:0] : {4'h0, ACC[11:0]}))
      else $error("write data wrong");
   a_wr_done: assert property (MEM_WR |=> DONE)
      else $error("no done after write");
   cover property (go && jmp);
   cover property (MEM_WR && lng);
   cover property (go && mop && D_FIELD == 6'h00);
endmodule // ppx_exec_assertions
bind ppx_exec ppx_exec_assertions #(.AW(AW), .DW(DW), .ACCW(ACCW)) i_chk (
   .REF_CLK, .RST, .START, .OPCODE, .D_FIELD, .M_FIELD, .PROG_ADDR, .BUSY, .DONE,
   .NEXT_PROG_ADDR, .ACC, .MEM_RD, .MEM_WR, .MEM_ADDR, .MEM_WDATA);

// [ppx_mem.sv]
// Processor memory model with one-cycle registered read
`timescale 1ns/1ps
module ppx_mem (
   input wire clk,
   input wire rd,
   input wire wr,
   input wire [11:0] addr,
   input wire [15:0] wdata,
   output reg [15:0] rdata
);
   reg [15:0] mem [0:4095];
   initial rdata = 16'h0000;
   always @(posedge clk) begin
      if (wr) mem[addr] <= wdata;
      // Stale data flips, so a late sample cannot pass
      if (rd) rdata <= mem[addr];
      else rdata <= ~rdata;
   end
endmodule // ppx_mem

// [tb_top.sv]
// Self-checking bench for the execution block
`timescale 1ns/1ps
module tb_top;
   reg REF_CLK = 1'b0, RST = 1'b1, START = 1'b0;
   reg [9:0] OPCODE = 10'h000;
   reg [5:0] D_FIELD = 6'h00;
   reg [15:0] M_FIELD = 16'h0000;
   reg [11:0] PROG_ADDR = 12'h000;
   wire BUSY, DONE, ILLEGAL, MEM_RD, MEM_WR;
   wire [11:0] NEXT_PROG_ADDR, MEM_ADDR;
   wire [17:0] ACC;
   wire [15:0] MEM_WDATA, MEM_RDATA;
   reg [17:0] acc_m = 18'h00000;
   integer fail_count = 0, n_compared = 0;
   always #12.5 REF_CLK = ~REF_CLK;
   ppx_exec i_dut (.REF_CLK, .RST, .START, .OPCODE, .D_FIELD, .M_FIELD, .PROG_ADDR, .BUSY, .DONE, .ILLEGAL,
      .NEXT_PROG_ADDR, .ACC, .MEM_RD, .MEM_WR, .MEM_ADDR, .MEM_WDATA, .MEM_RDATA);
   ppx_mem i_mem (.clk(REF_CLK), .rd(MEM_RD), .wr(MEM_WR), .addr(MEM_ADDR), .wdata(MEM_WDATA), .rdata(MEM_RDATA));
   ////////////////////////////////////////////////////////////////////////////////
   task end_sim;
      begin
         $display("compared %0d mismatches %0d", n_compared, fail_count);
         if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   task check(input [79:0] what, input [17:0] seen, input [17:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   function [17:0] add_oc(input [17:0] a, input [17:0] b, input w12);
      reg [18:0] s;
      begin
         s = w12 ? a[11:0] + b[11:0] : a + b;
         add_oc = w12 ? (s[11:0] + s[12]) & 18'h00fff : s[17:0] + s[18];
      end
   endfunction
   task issue(input [9:0] op, input [5:0] d, input [15:0] m, input [11:0] p);
      integer i;
      begin
         @(posedge REF_CLK);
         OPCODE <= op;
         D_FIELD <= d;
         M_FIELD <= m;
         PROG_ADDR <= p;
         START <= 1'b1;
         @(posedge REF_CLK);
         START <= 1'b0;
         // Settle past the taking edge, else a one-cycle jump DONE is missed
         #1;
         // Only the memory group carries opcode bit 5 and stays busy
         check("busy", BUSY, op[5]);
         for (i = 0; i < 12 && DONE !== 1'b1; i = i + 1) begin
            @(posedge REF_CLK);
            #1;
         end
         check("done", DONE, 1'b1);
         check("illegal", ILLEGAL, op == 10'h007);
         if (DONE !== 1'b1) end_sim;
      end
   endtask
   task run_mem(input [9:0] op, input [5:0] d, input [15:0] m, input [11:0] p);
      reg [11:0] a;
      reg [17:0] opnd;
      begin
         a = op == 10'h227 ? i_mem.mem[d][11:0] : d != 0 ? add_oc(m, i_mem.mem[d], 1'b1) : m[11:0];
         opnd = op[9] ? {2'b00, i_mem.mem[a]} : {6'h00, i_mem.mem[a][11:0]};
         acc_m = add_oc(op[1:0] == 2'b01 ? acc_m : op[1:0] == 2'b10 ? 18'h00001 : 18'h3fffe, opnd, 1'b0);
         issue(op, d, m, p);
         check("acc", ACC, acc_m);
         check("mem", i_mem.mem[a], op[9] ? acc_m[15:0] : acc_m[11:0]);
         check("next", NEXT_PROG_ADDR, p + (op == 10'h227 ? 12'd1 : 12'd2));
      end
   endtask
   task run_jmp(input [9:0] op, input [5:0] d, input [11:0] p, input taken);
      reg [11:0] t;
      begin
         t = !taken ? p + 12'd1 : d[5] ? p - (12'd63 - d) : p + d;
         issue(op, d, 16'h0000, p);
         check("target", NEXT_PROG_ADDR, t);
         check("acc_kept", ACC, acc_m);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task s_jump_acc_zero;
      begin
         check("rst_acc", ACC, 18'h00000);
         run_jmp(10'h003, 6'd31, 12'h100, 1'b1);
         run_jmp(10'h004, 6'd40, 12'h100, 1'b1);
         run_jmp(10'h005, 6'd3, 12'h100, 1'b0);
         run_jmp(10'h006, 6'd63, 12'h100, 1'b1);
      end
   endtask
   task s_index_short;
      begin
         i_mem.mem[3] = 16'h0010;
         i_mem.mem[12'h015] = 16'ha800;
         run_mem(10'h02f, 6'd3, 16'h0005, 12'h100);
         run_mem(10'h02d, 6'd3, 16'h0005, 12'h100);
         run_mem(10'h02e, 6'd3, 16'h0005, 12'h100);
      end
   endtask
   task s_index_long_wrap;
      begin
         i_mem.mem[4] = 16'h0ffe;
         i_mem.mem[12'h01f] = 16'hfffe;
         run_mem(10'h22e, 6'd4, 16'hf020, 12'h100);
         run_mem(10'h22f, 6'd4, 16'hf020, 12'h100);
         run_mem(10'h22d, 6'd0, 16'h001f, 12'h100);
      end
   endtask
   task s_indirect_then_jumps;
      begin
         i_mem.mem[5] = 16'hf030;
         i_mem.mem[12'h030] = 16'h0000;
         run_mem(10'h227, 6'd5, 16'h0000, 12'h200);
         run_jmp(10'h004, 6'd2, 12'h200, 1'b0);
         run_jmp(10'h005, 6'd33, 12'h200, 1'b1);
         run_jmp(10'h006, 6'd4, 12'h200, 1'b0);
         run_jmp(10'h003, 6'd32, 12'h200, 1'b1);
      end
   endtask
   task s_illegal;
      begin
         issue(10'h007, 6'd5, 16'h0000, 12'h300);
         check("ill_next", NEXT_PROG_ADDR, 12'h301);
         check("ill_acc", ACC, acc_m);
      end
   endtask
   initial begin
      repeat (2) @(posedge REF_CLK);
      RST <= 1'b0;
      @(posedge REF_CLK);
      #1;
      s_jump_acc_zero;
      s_index_short;
      s_index_long_wrap;
      s_indirect_then_jumps;
      s_illegal;
      end_sim;
   end
endmodule // tb_top
